// File: hdl/mbpwm_consts.vh
/*
   Constants of the match based pwm timer: register byte offsets on the
   APB window, control and selection field positions, reset values.
   Assumes it is included by bare name from the design files.
*/
`ifndef MBPWM_CONSTS_VH
`define MBPWM_CONSTS_VH

// register byte offsets (word aligned)
`define MBPWM_OFF_STATUS    8'h00
`define MBPWM_OFF_CTRL      8'h04
`define MBPWM_OFF_COUNT     8'h08
`define MBPWM_OFF_PRESCALE  8'h0c
`define MBPWM_OFF_PRECOUNT  8'h10
`define MBPWM_OFF_MATCHCTL  8'h14
`define MBPWM_OFF_MATCH0    8'h18
`define MBPWM_OFF_MATCH6    8'h30
`define MBPWM_OFF_PWMSEL    8'h34
`define MBPWM_OFF_RELEASE   8'h38
`define MBPWM_OFF_MASK      8'h3c

// control register fields
`define MBPWM_CTRL_EN       0
`define MBPWM_CTRL_CRST     1
`define MBPWM_CTRL_PWM      3

// match control: three bits per match register
`define MBPWM_MC_INT        0
`define MBPWM_MC_RST        1
`define MBPWM_MC_STOP       2
`define MBPWM_MC_W          3

// pwm select: double edge bits 2..6, output enables from bit 9
`define MBPWM_SEL_DBL       0
`define MBPWM_SEL_OE        8
`define MBPWM_SEL_MASK      15'h7e7c

// reset values
`define MBPWM_RST_CTRL      4'h0
`define MBPWM_RST_WORD      32'h00000000
`define MBPWM_RST_SEL       15'h0000
`define MBPWM_RST_FLAGS     7'h00
`define MBPWM_RST_MCTL      21'h000000

`endif

// File: hdl/mbpwm_chan.v
/*
   One modulated output of the match based pwm timer: single or double
   edge control. Assumes match events are one-cycle pulses on the same
   clock and that the cycle start event is the period match.
*/
`timescale 1ns/1ps
`default_nettype none

module mbpwm_chan
(
   input  wire clk_i,      // system clock
   input  wire rst_n_i,    // synchronous reset, active low
   input  wire pwm_en_i,   // modulation mode on
   input  wire out_en_i,   // this output enabled
   input  wire dbl_i,      // double edge mode
   input  wire start_ev_i, // cycle period match
   input  wire rise_ev_i,  // rising edge match in double mode
   input  wire fall_ev_i,  // falling edge match
   output reg  pwm_o       // modulated level
);

   wire set_ev;

   assign set_ev = dbl_i ? rise_ev_i : start_ev_i;

   always @(posedge clk_i)
   begin
      if (!rst_n_i)
         pwm_o <= 1'b0;
      else if (!(pwm_en_i && out_en_i))
         pwm_o <= 1'b0;
      // falling match wins a tie, so equal edges give a constant low
      else if (fall_ev_i)
         pwm_o <= 1'b0;
      else if (set_ev)
         pwm_o <= 1'b1;
   end
   // rise before fall gives a positive pulse, fall first a negative one

endmodule // mbpwm_chan

`default_nettype wire

// File: hdl/mbpwm_top.v
/*
   Match based pwm timer: prescaled 32-bit counter, seven match registers
   with shadow copies, six modulated outputs, APB register slave and a
   level interrupt. Assumes one clock, an APB master on the same clock and
   external circuits on the outputs.
*/
// The APB interface to the registers and the address map were decided locally.
// Contract
// - count on clock, compare seven matches
// - 32-bit counter behind 32-bit prescaler
// - period match clears the count
// - single edge outputs rise at cycle start
// - one match per single edge output
// - two matches per double edge output
// - rise first positive, fall first negative
// - six single, three double, or mix
// - match continues, stops or resets, optional interrupt
// - all outputs share one period
// - any whole count for period, width
// - new matches applied at cycle start
// - plain timer when modulation disabled
// - all match events into one interrupt
`timescale 1ns/1ps
`default_nettype none
`include "mbpwm_consts.vh"

module mbpwm_top
#(
   parameter NMATCH = 7, // match registers
   parameter NOUT   = 6  // modulated outputs
)
(
   input  wire        CLK_SYS_I,   // system clock, 125 MHz
   input  wire        RST_N_I,     // synchronous reset, active low
   input  wire        PSEL_I,      // apb select
   input  wire        PENABLE_I,   // apb access phase
   input  wire        PWRITE_I,    // apb write
   input  wire [7:0]  PADDR_I,     // apb byte address
   input  wire [31:0] PWDATA_I,    // apb write data
   output reg  [31:0] PRDATA_O,    // apb read data
   output reg         PREADY_O,    // apb ready
   output reg         PSLVERR_O,   // apb error, unmapped address
   output reg         IRQ_O,       // interrupt, level high
   output wire [5:0]  PWM_O        // modulated outputs 1..6
);

   // apb decode
   wire        setup;
   wire        wr_acc;
   wire        rd_acc;
   wire        hit;
   wire [5:0]  widx;
   reg  [31:0] rd_mux;

   // control and state
   reg         en_q;
   reg         crst_q;
   reg         pwm_en_q;
   reg  [31:0] tc_q;
   reg  [31:0] pr_q;
   reg  [31:0] pc_q;
   reg  [20:0] mctl_q;
   reg  [14:0] sel_q;
   reg  [6:0]  rel_q;
   reg  [6:0]  flag_q;
   reg  [6:0]  mask_q;
   reg  [6:0]  rel_d;
   reg  [6:0]  flag_d;
   reg  [6:0]  clr_flags;

   // match events
   wire        tick;
   wire [6:0]  ev;
   wire [6:0]  m_int;
   wire [6:0]  m_rst;
   wire [6:0]  m_stp;
   wire        cyc_start;
   wire        rst_m;
   wire        stop_m;
   wire [6:0]  apply;
   wire [223:0] sh_flat;

   assign setup  = PSEL_I & ~PENABLE_I;
   assign wr_acc = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I & ~PSLVERR_O;
   assign rd_acc = PSEL_I & PENABLE_I & PREADY_O & ~PWRITE_I & ~PSLVERR_O;
   assign widx   = PADDR_I[7:2];
   assign hit    = (PADDR_I[1:0] == 2'b00) && (PADDR_I <= `MBPWM_OFF_MASK);

   // prescaler rolls over when it reaches the programmed limit; at or past
   // it, so a smaller limit written mid-count cannot stall the count
   assign tick = en_q & ~crst_q & (pc_q >= pr_q);

   genvar g;
   generate
      for (g = 0; g < NMATCH; g = g + 1)
      begin : gm
         reg [31:0] sh_q;
         reg [31:0] act_q;
         // byte offset of this match word, sliced on purpose below
         wire [31:0] moff;
         assign moff = g * 4;
         assign sh_flat[g*32 +: 32]  = sh_q;
         assign ev[g]    = tick & (tc_q == act_q);
         assign m_int[g] = mctl_q[g*`MBPWM_MC_W + `MBPWM_MC_INT];
         assign m_rst[g] = mctl_q[g*`MBPWM_MC_W + `MBPWM_MC_RST];
         assign m_stp[g] = mctl_q[g*`MBPWM_MC_W + `MBPWM_MC_STOP];

         always @(posedge CLK_SYS_I)
         begin
            if (!RST_N_I)
            begin
               sh_q  <= `MBPWM_RST_WORD;
               act_q <= `MBPWM_RST_WORD;
            end
            else
            begin
               if (wr_acc && (PADDR_I == `MBPWM_OFF_MATCH0 + moff[7:0]))
                  sh_q <= PWDATA_I;
               // timer mode takes values at once; pwm mode waits for release
               if (!pwm_en_q)
                  act_q <= sh_q;
               else if (apply[g])
                  act_q <= sh_q;
            end
         end
      end
   endgenerate

   // modulation forces the period match to reset the count
   assign cyc_start = ev[0];
   assign rst_m     = |(ev & m_rst) | (pwm_en_q & cyc_start);
   assign stop_m    = |(ev & m_stp);
   // released values go live only at the cycle boundary
   assign apply     = {7{pwm_en_q & cyc_start}} & rel_q;

   // counter and prescaler
   always @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
      begin
         tc_q <= `MBPWM_RST_WORD;
         pc_q <= `MBPWM_RST_WORD;
      end
      // a count write restarts the prescale phase too
      else if (wr_acc && PADDR_I == `MBPWM_OFF_COUNT)
      begin
         tc_q <= PWDATA_I;
         pc_q <= `MBPWM_RST_WORD;
      end
      else if (crst_q)
      begin
         tc_q <= `MBPWM_RST_WORD;
         pc_q <= `MBPWM_RST_WORD;
      end
      else if (en_q)
      begin
         if (tick)
         begin
            pc_q <= `MBPWM_RST_WORD;
            // wraps at the full width when no period is set
            tc_q <= rst_m ? `MBPWM_RST_WORD : tc_q + 32'h00000001;
         end
         else
            pc_q <= pc_q + 32'h00000001;
      end
   end

   // control registers
   always @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
      begin
         en_q     <= 1'b0;
         crst_q   <= 1'b0;
         pwm_en_q <= 1'b0;
         pr_q     <= `MBPWM_RST_WORD;
         mctl_q   <= `MBPWM_RST_MCTL;
         sel_q    <= `MBPWM_RST_SEL;
         mask_q   <= `MBPWM_RST_FLAGS;
      end
      else
      begin
         // a software enable in the stop cycle wins
         if (wr_acc && PADDR_I == `MBPWM_OFF_CTRL)
         begin
            en_q     <= PWDATA_I[`MBPWM_CTRL_EN];
            crst_q   <= PWDATA_I[`MBPWM_CTRL_CRST];
            pwm_en_q <= PWDATA_I[`MBPWM_CTRL_PWM];
         end
         else if (stop_m)
            en_q <= 1'b0;
         if (wr_acc && PADDR_I == `MBPWM_OFF_PRESCALE)
            pr_q <= PWDATA_I;
         if (wr_acc && PADDR_I == `MBPWM_OFF_MATCHCTL)
            mctl_q <= PWDATA_I[20:0];
         // output 1 has no double edge pair, so its bit stays zero
         if (wr_acc && PADDR_I == `MBPWM_OFF_PWMSEL)
            sel_q <= PWDATA_I[14:0] & `MBPWM_SEL_MASK;
         if (wr_acc && PADDR_I == `MBPWM_OFF_MASK)
            mask_q <= PWDATA_I[6:0];
      end
   end

   // release bits and sticky flags: a set wins over a clear in the same cycle
   always @*
   begin
      rel_d = rel_q & ~apply;
      if (wr_acc && PADDR_I == `MBPWM_OFF_RELEASE)
         rel_d = rel_d | PWDATA_I[6:0];
      clr_flags = 7'h00;
      if (wr_acc && PADDR_I == `MBPWM_OFF_STATUS)
         clr_flags = PWDATA_I[6:0];
      // only the bits software actually saw are cleared by a read
      else if (rd_acc && PADDR_I == `MBPWM_OFF_STATUS)
         clr_flags = PRDATA_O[6:0];
      flag_d = (flag_q & ~clr_flags) | (ev & m_int);
   end

   always @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
      begin
         rel_q  <= `MBPWM_RST_FLAGS;
         flag_q <= `MBPWM_RST_FLAGS;
         IRQ_O  <= 1'b0;
      end
      else
      begin
         rel_q  <= rel_d;
         flag_q <= flag_d;
         // one line for all seven matches
         IRQ_O  <= |(flag_q & mask_q);
      end
   end

   // read mux, sampled in the setup phase
   always @*
   begin
      rd_mux = 32'h00000000;
      case (PADDR_I)
         `MBPWM_OFF_STATUS:   rd_mux = {25'h0000000, flag_q};
         `MBPWM_OFF_CTRL:     rd_mux = {28'h0000000, pwm_en_q, 1'b0, crst_q, en_q};
         `MBPWM_OFF_COUNT:    rd_mux = tc_q;
         `MBPWM_OFF_PRESCALE: rd_mux = pr_q;
         `MBPWM_OFF_PRECOUNT: rd_mux = pc_q;
         `MBPWM_OFF_MATCHCTL: rd_mux = {11'h000, mctl_q};
         `MBPWM_OFF_PWMSEL:   rd_mux = {17'h00000, sel_q};
         `MBPWM_OFF_RELEASE:  rd_mux = {25'h0000000, rel_q};
         `MBPWM_OFF_MASK:     rd_mux = {25'h0000000, mask_q};
         default:
         begin
            // match shadows take one word each from the first match upward
            if (hit && PADDR_I >= `MBPWM_OFF_MATCH0)
               rd_mux = sh_flat[(widx - 6'h06)*32 +: 32];
            else
               rd_mux = 32'h00000000;
         end
      endcase
   end

   // apb answer: ready and error come up in the access phase, no wait
   always @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
      begin
         PRDATA_O  <= `MBPWM_RST_WORD;
         PREADY_O  <= 1'b0;
         PSLVERR_O <= 1'b0;
      end
      else
      begin
         PREADY_O  <= setup;
         PSLVERR_O <= setup & ~hit;
         if (setup)
            PRDATA_O <= hit ? rd_mux : 32'h00000000;
      end
   end

   // modulated outputs, one period for all of them
   generate
      for (g = 1; g <= NOUT; g = g + 1)
      begin : go
         mbpwm_chan u_chan
         (
            .clk_i      (CLK_SYS_I),
            .rst_n_i    (RST_N_I),
            .pwm_en_i   (pwm_en_q),
            .out_en_i   (sel_q[`MBPWM_SEL_OE + g]),
            .dbl_i      (sel_q[`MBPWM_SEL_DBL + g]),
            .start_ev_i (cyc_start),
            .rise_ev_i  (ev[g-1]),
            .fall_ev_i  (ev[g]),
            .pwm_o      (PWM_O[g-1])
         );
      end
   endgenerate

endmodule // mbpwm_top

`default_nettype wire

// File: verification/mbpwm_checker.sv
/* Port assertions of mbpwm_top.
   Assumes one clock and the bind below. */
`timescale 1ns/1ps
`default_nettype none
module mbpwm_checker #(parameter NMATCH = 7, parameter NOUT = 6)
(
   input wire logic        CLK_SYS_I, // clock
   input wire logic        RST_N_I,   // reset
   input wire logic        PSEL_I,    // select
   input wire logic        PENABLE_I, // access
   input wire logic        PWRITE_I,  // direction
   input wire logic [7:0]  PADDR_I,   // address
   input wire logic [31:0] PWDATA_I,  // write data
   input wire logic [31:0] PRDATA_O,  // read data
   input wire logic        PREADY_O,  // ready
   input wire logic        PSLVERR_O, // error
   input wire logic        IRQ_O,     // interrupt
   input wire logic [5:0]  PWM_O      // outputs
);
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (!RST_N_I);
   sequence s_setup;
      PSEL_I && !PENABLE_I;
   endsequence
   sequence s_xfer;
      s_setup ##1 PSEL_I && PENABLE_I;
   endsequence
   a_access_ready: assert property (s_xfer |-> PREADY_O) else $error("no ready");
   a_ready_only: assert property (!(PSEL_I && !PENABLE_I) |=> !PREADY_O) else $error("ready");
   a_ready_single: assert property (PREADY_O |=> !PREADY_O) else $error("ready held");
   a_err_unmapped: assert property (s_setup ##0 (PADDR_I > 8'h3c || PADDR_I[1:0] != 2'h0)
      |=> PSLVERR_O && PRDATA_O == 32'h0) else $error("no error");
   a_err_mapped: assert property (s_setup ##0 (PADDR_I <= 8'h3c && PADDR_I[1:0] == 2'h0)
      |=> !PSLVERR_O) else $error("false error");
   a_err_ready: assert property (PSLVERR_O |-> PREADY_O) else $error("error alone");
   a_rdata_held: assert property (!(PSEL_I && !PENABLE_I) |=> $stable(PRDATA_O))
      else $error("read data moved");
   a_irq_sticky: assert property ($fell(IRQ_O) |-> $past(PSEL_I, 2))
      else $error("interrupt dropped");
   a_reset_quiet: assert property (@(posedge CLK_SYS_I) disable iff (1'b0)
      !RST_N_I |=> PWM_O == 6'h0 && !IRQ_O) else $error("not quiet");
endmodule // mbpwm_checker
bind mbpwm_top mbpwm_checker #(.NMATCH(NMATCH), .NOUT(NOUT)) chk_u (.CLK_SYS_I(CLK_SYS_I),
   .RST_N_I(RST_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
   .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
   .PSLVERR_O(PSLVERR_O), .IRQ_O(IRQ_O), .PWM_O(PWM_O));
`default_nettype wire

// File: verification/mbpwm_load.sv
/* Load on one modulated output: last high run and last period in clocks.
   Assumes the level changes only at rising clock edges. */
`timescale 1ns/1ps
`default_nettype none
module mbpwm_load
(
   input  wire logic        clk_i, // system clock
   input  wire logic        lvl_i, // output level
   output var  logic [15:0] hi_o,  // last high run
   output var  logic [15:0] per_o  // last rise to rise
);
   logic [15:0] hc = 16'h0;
   logic [15:0] pc = 16'h0;
   logic        lv = 1'b0;
   always @(posedge clk_i)
   begin
      lv <= lvl_i;
      pc <= (lvl_i && !lv) ? 16'h1 : pc + 16'h1;
      hc <= lvl_i ? (lv ? hc : 16'h0) + 16'h1 : hc;
      if (lvl_i && !lv)
         per_o <= pc;
      if (!lvl_i && lv)
         hi_o <= hc;
   end
endmodule // mbpwm_load
`default_nettype wire

// File: verification/mbpwm_top_tb_top.sv
/* Testbench of mbpwm_top: APB master, random pwm settings, output loads.
   Assumes design, checker and load model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`include "mbpwm_consts.vh"
module mbpwm_top_tb_top;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        psel = 1'b0;
   logic        pen = 1'b0;
   logic        pwr = 1'b0;
   logic [7:0]  padr = 8'h00;
   logic [31:0] pwd = 32'h0;
   logic [31:0] prd;
   logic        prdy;
   logic        perr;
   logic        irq;
   logic [5:0]  pwm;
   logic [15:0] hi [6];
   logic [15:0] per [6];
   logic [31:0] q;
   logic [31:0] q1;
   logic        e;
   int          bad_count = 0;
   int          checks = 0;
   int          p, w, k, f, n;
   mbpwm_top dut_u (.CLK_SYS_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
      .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy),
      .PSLVERR_O(perr), .IRQ_O(irq), .PWM_O(pwm));
   for (genvar i = 0; i < 6; i++)
   begin : g_load
      mbpwm_load load_u (.clk_i(clk), .lvl_i(pwm[i]), .hi_o(hi[i]), .per_o(per[i]));
   end
   initial forever #4 clk = ~clk;
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= wr;
      padr <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      // answer taken at the rising edge where ready is seen, not before
      do
      begin
         @(posedge clk);
      end
      while (prdy !== 1'b1);
      q = prd;
      e = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
      checks++;
      if (s !== x)
      begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, x, s);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   function automatic int dbl_hi(int rr, int ff, int pp);
      return (rr < ff) ? ff - rr : pp + 1 - (rr - ff);
   endfunction
   task automatic settle();
      repeat (4 * (p + 1) * (k + 1) + 8) @(posedge clk);
   endtask
   initial
   begin
      repeat (20000) @(posedge clk);
      bad_count++;
      end_of_test();
   end
   initial
   begin
      n = $urandom(78);
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      apb(1'b0, `MBPWM_OFF_CTRL, 32'h0);
      chk("ctrl", q, 32'h0);
      apb(1'b0, `MBPWM_OFF_COUNT, 32'h0);
      chk("count", q, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped", {31'h0, e}, 32'h1);
      for (int t = 0; t < 4; t++)
      begin
         p = 8 + $urandom % 30;
         w = (t == 0) ? p - 1 : 1 + $urandom % (p - 1);
         f = (t == 0) ? 0 : (w + 1 + $urandom % p) % (p + 1);
         k = $urandom % 3;
         // hold the count at zero so each setting starts on a clean cycle
         apb(1'b1, `MBPWM_OFF_CTRL, 32'h2);
         apb(1'b1, `MBPWM_OFF_PRESCALE, k);
         apb(1'b1, `MBPWM_OFF_MATCH0, p);
         apb(1'b1, `MBPWM_OFF_MATCH0 + 8'h04, w);
         apb(1'b1, `MBPWM_OFF_MATCH0 + 8'h08, f);
         apb(1'b1, `MBPWM_OFF_PWMSEL, 32'h604);
         apb(1'b1, `MBPWM_OFF_RELEASE, 32'h7);
         apb(1'b1, `MBPWM_OFF_CTRL, 32'h9);
         settle();
         chk("period1", per[0], (p + 1) * (k + 1));
         chk("high1", hi[0], (w + 1) * (k + 1));
         chk("period2", per[1], (p + 1) * (k + 1));
         chk("high2", hi[1], dbl_hi(w, f, p) * (k + 1));
         chk("unused", pwm[5:2], 4'h0);
      end
      apb(1'b1, `MBPWM_OFF_MATCH0 + 8'h04, w - 1);
      settle();
      chk("unreleased", hi[0], (w + 1) * (k + 1));
      apb(1'b1, `MBPWM_OFF_RELEASE, 32'h2);
      settle();
      chk("released", hi[0], w * (k + 1));
      apb(1'b1, `MBPWM_OFF_CTRL, 32'h0);
      apb(1'b1, `MBPWM_OFF_COUNT, 32'h0);
      apb(1'b1, `MBPWM_OFF_PRESCALE, 32'h0);
      apb(1'b1, `MBPWM_OFF_MATCH0 + 8'h0c, 32'd20);
      apb(1'b1, `MBPWM_OFF_MATCHCTL, 32'he00);
      apb(1'b1, `MBPWM_OFF_MASK, 32'h0);
      apb(1'b1, `MBPWM_OFF_CTRL, 32'h1);
      repeat (40) @(posedge clk);
      chk("plain", pwm, 6'h0);
      apb(1'b0, `MBPWM_OFF_CTRL, 32'h0);
      chk("stopped", q[0], 1'b0);
      apb(1'b0, `MBPWM_OFF_COUNT, 32'h0);
      q1 = q;
      chk("count reset", q1, 32'h0);
      apb(1'b0, `MBPWM_OFF_COUNT, 32'h0);
      chk("frozen", q, q1);
      chk("masked", irq, 1'b0);
      apb(1'b1, `MBPWM_OFF_MASK, 32'h8);
      repeat (3) @(posedge clk);
      chk("irq", irq, 1'b1);
      apb(1'b0, `MBPWM_OFF_STATUS, 32'h0);
      chk("flag", q[3], 1'b1);
      repeat (3) @(posedge clk);
      chk("cleared", irq, 1'b0);
      apb(1'b1, `MBPWM_OFF_CTRL, 32'h1);
      repeat (30) @(posedge clk);
      chk("irq again", irq, 1'b1);
      apb(1'b1, `MBPWM_OFF_STATUS, 32'h8);
      repeat (3) @(posedge clk);
      chk("write clear", irq, 1'b0);
      end_of_test();
   end
endmodule // mbpwm_top_tb_top
`default_nettype wire
